// file: hdl/cmd_fifo.v
// Purpose: command byte FIFO
// Assumes: one clock, synchronous reset
// Notes:   ready low when full, valid low when empty
`timescale 1ns/10ps
module cmd_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr_reg;
  reg [AW:0]      rdPtr_reg;
  wire            full;
  wire            empty;
  assign empty    = (wrPtr_reg == rdPtr_reg);
  assign full     = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) && (wrPtr_reg[AW] != rdPtr_reg[AW]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_reg[AW-1:0]];
  always @(posedge mclk) begin
    if (inValid && !full)
      mem[wrPtr_reg[AW-1:0]] <= inData;
  end
  always @(posedge mclk) begin
    if (reset) begin
      wrPtr_reg <= {(AW+1){1'b0}};
      rdPtr_reg <= {(AW+1){1'b0}};
    end else begin
      if (inValid && !full)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (outReady && !empty)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule // cmd_fifo

// file: hdl/host_interface_selector.v
// Purpose: picks which host port drives the shared command path
// Assumes: byte streams already deserialised per port, inputs synchronous
// Notes:   bytes from unselected ports are accepted and dropped
// Operation
// - Exactly one port feeds the command path and others are ignored.
// - Ranks are front USB 1, rear USB 2, network or instrument bus 3, RS485 5.
// - Attaching a USB cable takes control from RS485 to that USB port.
// - A command on the network or instrument bus takes control to that port.
// - After that, USB regains control only on reattach or power cycle.
// - RS485 has control only with both USB detached and no bus traffic.
// - RS485 is the default and is shown even with its wire off.
// - The active port is always shown, front and rear USB distinctly.
// - Serial framing is 115200 baud, 8 data, 1 stop, no parity, no flow.
// - Traffic is plain ASCII instrument command text.
`timescale 1ns/10ps
`include "host_select_consts.vh"
module host_interface_selector #(
  parameter BAUD_DIV = `BAUD_DIV,
  parameter DEPTH    = `FIFO_DEPTH
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire       frontUsbAttached,
  input  wire       rearUsbAttached,
  input  wire [7:0] frontUsbData,
  input  wire       frontUsbValid,
  input  wire [7:0] rearUsbData,
  input  wire       rearUsbValid,
  input  wire [7:0] netData,
  input  wire       netValid,
  input  wire [7:0] gpibData,
  input  wire       gpibValid,
  input  wire [7:0] serialData,
  input  wire       serialValid,
  output reg  [7:0] cmdData,
  output reg        cmdValid,
  input  wire       cmdReady,
  output reg  [3:0] activePort,
  output reg  [2:0] activeRank,
  output reg        netIsGpib,
  output reg        inputReady
);
  // States one-hot, equal to port codes
  localparam SEL_FRONT = 4'h1;
  localparam SEL_REAR  = 4'h2;
  localparam SEL_NET   = 4'h4;
  localparam SEL_485   = 4'h8;
  // byte width follows the serial frame
  localparam BYTE_W    = `FRAME_DATA_BITS;
  localparam FIFO_AW   = $clog2(DEPTH);

  reg [3:0] sel_reg;
  reg [3:0] sel_next;
  reg       gpibSel_reg;
  reg       gpibSel_next;
  wire [1:0] attached;
  wire [1:0] attachRise;
  wire      frontHeld;
  reg [7:0] muxData;
  reg       muxValid;
  wire      fifoReady;
  wire [7:0] fifoData;
  wire      fifoValid;
  wire      frontRise;
  wire      rearRise;
  wire      busCmd;

  assign attached  = {rearUsbAttached, frontUsbAttached};
  assign frontHeld = (sel_reg == SEL_FRONT) && frontUsbAttached;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_attach
      // Cleared by reset so a cable present at power-up counts as new
      reg attachPrev_reg;
      always @(posedge mclk) begin
        if (reset) begin
          attachPrev_reg <= 1'b0;
        end else begin
          attachPrev_reg <= attached[g];
        end
      end
      assign attachRise[g] = attached[g] && !attachPrev_reg;
    end
  endgenerate

  assign frontRise = attachRise[0];
  assign rearRise  = attachRise[1];
  assign busCmd    = netValid || gpibValid;

  function [2:0] rankOf;
    input [3:0] s;
    begin
      case (s)
        SEL_FRONT: rankOf = `RANK_FRONT_USB;
        SEL_REAR:  rankOf = `RANK_REAR_USB;
        SEL_NET:   rankOf = `RANK_NET;
        default:   rankOf = `RANK_SERIAL485;
      endcase
    end
  endfunction

  always @* begin
    sel_next     = sel_reg;
    gpibSel_next = gpibSel_reg;
    if (busCmd) begin
      sel_next = SEL_NET;
      // latest bus sender wins; instrument bus wins a same-cycle tie
      gpibSel_next = gpibValid;
    end else if (frontRise) begin
      sel_next = SEL_FRONT;
    // rear attach never displaces a held front port
    end else if (rearRise && !frontHeld) begin
      sel_next = SEL_REAR;
    end else begin
      case (sel_reg)
        SEL_FRONT: begin
          if (!frontUsbAttached) begin
            sel_next = rearUsbAttached ? SEL_REAR : SEL_485;
          end
        end
        SEL_REAR: begin
          if (!rearUsbAttached) begin
            sel_next = frontUsbAttached ? SEL_FRONT : SEL_485;
          end
        end
        SEL_NET:   sel_next = SEL_NET;
        SEL_485: begin
          if (frontUsbAttached)
            sel_next = SEL_FRONT;
          else if (rearUsbAttached)
            sel_next = SEL_REAR;
        end
        default:   sel_next = SEL_485;
      endcase
    end
  end

  always @* begin
    muxData  = serialData;
    muxValid = 1'b0;
    case (sel_reg)
      SEL_FRONT: begin
        muxData  = frontUsbData;
        muxValid = frontUsbValid;
      end
      SEL_REAR: begin
        muxData  = rearUsbData;
        muxValid = rearUsbValid;
      end
      SEL_NET: begin
        muxData  = gpibSel_reg ? gpibData : netData;
        muxValid = gpibSel_reg ? gpibValid : netValid;
      end
      SEL_485: begin
        muxData  = serialData;
        muxValid = serialValid;
      end
      default: begin
        muxData  = serialData;
        muxValid = 1'b0;
      end
    endcase
  end

  // Depth absorbs bursts while the parser is busy
  cmd_fifo #(.WIDTH(BYTE_W), .DEPTH(DEPTH), .AW(FIFO_AW)) fifo (
    .mclk     (mclk),
    .reset    (reset),
    .inData   (muxData),
    .inValid  (muxValid),
    .inReady  (fifoReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (cmdReady)
  );

  always @(posedge mclk) begin
    if (reset) begin
      sel_reg     <= SEL_485;
      gpibSel_reg <= 1'b0;
    end else begin
      sel_reg     <= sel_next;
      gpibSel_reg <= gpibSel_next;
    end
  end

  // bytes pass unaltered
  // Pulse per popped byte so a stall never repeats one
  always @(posedge mclk) begin
    if (reset) begin
      cmdData  <= 8'h00;
      cmdValid <= 1'b0;
    end else begin
      cmdValid <= fifoValid && cmdReady;
      if (fifoValid && cmdReady) begin
        cmdData <= fifoData;
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      activePort <= `PORT_SERIAL485;
      activeRank <= `RANK_SERIAL485;
      netIsGpib  <= 1'b0;
    end else begin
      activePort <= sel_next;
      activeRank <= rankOf(sel_next);
      netIsGpib  <= gpibSel_next;
    end
  end

  // One cycle late; senders must allow slack of one byte
  always @(posedge mclk) begin
    if (reset) begin
      inputReady <= 1'b0;
    end else begin
      inputReady <= fifoReady;
    end
  end
endmodule // host_interface_selector

// file: shared/host_select_consts.vh
// Purpose: constants for the host port selector
// Assumes: 100 MHz mclk
// Notes:   port codes double as one-hot select values
`ifndef HOST_SELECT_CONSTS_VH
`define HOST_SELECT_CONSTS_VH
`define PORT_FRONT_USB   4'h1
`define PORT_REAR_USB    4'h2
`define PORT_NET         4'h4
`define PORT_SERIAL485   4'h8
`define RANK_FRONT_USB   3'h1
`define RANK_REAR_USB    3'h2
`define RANK_NET         3'h3
`define RANK_SERIAL485   3'h5
`define BAUD_RATE        115200
`define CLK_HZ           100000000
`define BAUD_DIV         (`CLK_HZ / `BAUD_RATE)
`define FRAME_DATA_BITS  8
`define FRAME_STOP_BITS  1
`define FIFO_DEPTH       16
`endif

// file: sim/host_interface_selector_props.sv
// Purpose: port selector checks
// Assumes: bound to the selector top
// Notes:   one clock domain
`timescale 1ns/10ps
module host_interface_selector_props (
  input wire       mclk,
  input wire       reset,
  input wire       frontUsbAttached,
  input wire       rearUsbAttached,
  input wire       rearUsbValid,
  input wire       netValid,
  input wire       gpibValid,
  input wire       cmdValid,
  input wire       cmdReady,
  input wire       inputReady,
  input wire [3:0] activePort,
  input wire [2:0] activeRank,
  input wire       netIsGpib
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire busCmd = netValid | gpibValid;
  property p_one; $onehot(activePort); endproperty
  a_one: assert property (p_one) else $error("select not one-hot");
  property p_rank; activeRank == (activePort[0] ? 3'h1 : activePort[1] ? 3'h2 :
    activePort[2] ? 3'h3 : 3'h5); endproperty
  a_rank: assert property (p_rank) else $error("rank mismatch");
  property p_usb; $rose(frontUsbAttached) && activePort == 4'h8 && !busCmd
    |=> activePort == 4'h1; endproperty
  a_usb: assert property (p_usb) else $error("attach ignored");
  property p_net; busCmd |=> activePort == 4'h4; endproperty
  a_net: assert property (p_net) else $error("bus command ignored");
  property p_hold; activePort == 4'h4 && !$rose(frontUsbAttached) &&
    !$rose(rearUsbAttached) |=> activePort == 4'h4; endproperty
  a_hold: assert property (p_hold) else $error("bus control lost");
  property p_fall; $fell(frontUsbAttached) && !rearUsbAttached && !busCmd &&
    activePort == 4'h1 |=> activePort == 4'h8; endproperty
  a_fall: assert property (p_fall) else $error("no serial fallback");
  property p_src; busCmd |=> netIsGpib == $past(gpibValid); endproperty
  a_src: assert property (p_src) else $error("bus source wrong");
  property p_lat; rearUsbValid && activePort == 4'h2 && inputReady
    |-> ##[2:40] cmdValid; endproperty
  a_lat: assert property (p_lat) else $error("byte not forwarded");
  property p_rdy; cmdValid |-> $past(cmdReady); endproperty
  a_rdy: assert property (p_rdy) else $error("valid without ready");
  property p_rst; $past(reset) |-> activePort == 4'h8 && !cmdValid; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  cover property (busCmd ##1 activePort == 4'h4);
  cover property ($rose(frontUsbAttached));
  cover property (!inputReady);
endmodule // host_interface_selector_props
bind host_interface_selector host_interface_selector_props u_props (.*);

// file: sim/host_model.sv
// Purpose: host byte source
// Assumes: called just after rising edges
// Notes:   idle data is inverted
`timescale 1ns/10ps
module host_model (
  input  wire        mclk,
  output logic [7:0] data,
  output logic       valid
);
  initial begin
    data = 8'h00;
    valid = 1'b0;
  end
  task automatic burst(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      data <= b + i[7:0];
      valid <= 1'b1;
      @(posedge mclk);
    end
    valid <= 1'b0;
    data <= ~data;
  endtask
endmodule // host_model

// file: sim/tb_top.sv
// Purpose: selector testbench
// Assumes: short checker latency bounds
// Notes:   stalls parser to fill buffer
`timescale 1ns/10ps
module tb_top;
  logic       mclk, reset, fAtt, rAtt, cmdReady;
  wire  [7:0] fD, rD, nD, gD, sD, cmdData;
  wire        fV, rV, nV, gV, sV, cmdValid, inputReady, netIsGpib;
  wire  [3:0] activePort;
  wire  [2:0] activeRank;
  int         nFail = 0, samplesChecked = 0, nOut = 0, k;
  logic [7:0] lastOut;
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  host_model u_front (.mclk(mclk), .data(fD), .valid(fV));
  host_model u_rear (.mclk(mclk), .data(rD), .valid(rV));
  host_model u_net (.mclk(mclk), .data(nD), .valid(nV));
  host_model u_gpib (.mclk(mclk), .data(gD), .valid(gV));
  host_model u_ser (.mclk(mclk), .data(sD), .valid(sV));
  host_interface_selector #(.DEPTH(16)) u_dut (.mclk(mclk), .reset(reset),
    .frontUsbAttached(fAtt), .rearUsbAttached(rAtt), .frontUsbData(fD),
    .frontUsbValid(fV), .rearUsbData(rD), .rearUsbValid(rV), .netData(nD),
    .netValid(nV), .gpibData(gD), .gpibValid(gV), .serialData(sD),
    .serialValid(sV), .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .activePort(activePort), .activeRank(activeRank), .netIsGpib(netIsGpib),
    .inputReady(inputReady));
  always @(posedge mclk) if (cmdValid) begin
    nOut <= nOut + 1;
    lastOut <= cmdData;
  end
  task check(input string what, input logic [7:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task step(int n); repeat (n) @(posedge mclk); endtask
  task waitOut(int n);
    for (int i = 0; i < 60 && nOut < n; i++) @(posedge mclk);
  endtask
  task sel(logic [3:0] p, logic [2:0] r);
    check("port", {4'h0, activePort}, {4'h0, p});
    check("rank", {5'h0, activeRank}, {5'h0, r});
  endtask
  task summarize;
    $display("checks %0d fails %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_usb;
    sel(4'h8, 3'h5);
    u_ser.burst(8'h53, 1);
    waitOut(1);
    check("out", lastOut, 8'h53);
    fAtt <= 1;
    step(2);
    sel(4'h1, 3'h1);
    fork u_front.burst(8'h41, 1); u_rear.burst(8'h42, 1); join
    step(12);
    check("drop", nOut[7:0], 8'h02);
    check("out", lastOut, 8'h41);
    rAtt <= 1;
    step(2);
    sel(4'h1, 3'h1);
    rAtt <= 0;
    fAtt <= 0;
    step(2);
    sel(4'h8, 3'h5);
    rAtt <= 1;
    step(2);
    sel(4'h2, 3'h2);
    $display("done usb");
  endtask
  task t_net;
    u_net.burst(8'h4e, 1);
    step(2);
    sel(4'h4, 3'h3);
    check("src", {7'h0, netIsGpib}, 8'h00);
    u_gpib.burst(8'h47, 1);
    step(2);
    check("src", {7'h0, netIsGpib}, 8'h01);
    step(8);
    k = nOut;
    u_rear.burst(8'h52, 1);
    rAtt <= 0;
    step(10);
    check("drop", nOut[7:0], k[7:0]);
    sel(4'h4, 3'h3);
    rAtt <= 1;
    step(2);
    sel(4'h2, 3'h2);
    $display("done net");
  endtask
  task t_fifo;
    k = nOut;
    cmdReady <= 0;
    u_rear.burst(8'h30, 20);
    step(2);
    check("full", {7'h0, inputReady}, 8'h00);
    cmdReady <= 1;
    waitOut(k + 16);
    step(5);
    check("count", nOut[7:0] - k[7:0], 8'h10);
    check("last", lastOut, 8'h3f);
    rAtt <= 0;
    step(2);
    sel(4'h8, 3'h5);
    $display("done fifo");
  endtask
  initial begin
    fAtt = 0;
    rAtt = 0;
    cmdReady = 1;
    reset = 1;
    step(8);
    reset <= 0;
    step(2);
    t_usb;
    t_net;
    t_fifo;
    summarize;
  end
  initial begin
    #20000;
    nFail++;
    summarize;
  end
endmodule // tb_top
